//--- logic/msi_vpd_capability_regs.sv
// Purpose: Capability register bank of one switch port over AHB-Lite
// Assumes: Single word transfers, zero wait states, OKAY only
// Notes: Port role strap picks which capability group is present
//
// What this block does
// - MSI enable gates message writes, stops INTx
// - 64-bit address capable bit reads one
// - Message address uses bits 31:2 only
// - Upper address used only in 64-bit mode
// - Message capability present on downstream ports only
// - Product-data capability present on upstream only
// - Product-data header reads 03h, next 64h
// - Six-bit address selects table location
// - Writes allowed only with write-enable set
// - Op zero starts read, sets one on completion
// - Op one starts write, clears on completion
// - Data register returns last fetched word
// - Data register write supplies next stored word
// - Vendor header reads 09h, next B0h
// - Vendor header length field reads 34h
// - Message header reads 05h, next 64h
`timescale 1ns/1ps
module msi_vpd_capability_regs
   import cap_regs_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Port role strap, high for downstream port
   input wire logic port_is_downstream,
   // Service request from the port
   input wire logic irq_req,
   input wire logic irq_level,
   // Message write to the fabric
   output logic msg_wr_valid,
   input wire logic msg_wr_ready,
   output logic [63:0] msg_wr_addr,
   output logic [31:0] msg_wr_payload,
   output logic intx_assert,
   // EEPROM controller
   output logic ee_req,
   output logic ee_write,
   output logic [PD_ADDR_W-1:0] ee_addr,
   output logic [31:0] ee_wdata,
   input wire logic ee_done,
   input wire logic [31:0] ee_rdata,
   // Interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic down_r;
   logic strap_done_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic msi_en_r;
   logic [2:0] mme_r;
   logic [29:0] msg_addr_r;
   logic [31:0] msg_uaddr_r;
   logic [15:0] msg_data_r;
   logic [PD_ADDR_W-1:0] pd_addr_r;
   logic pd_wen_r;
   logic pd_op_r;
   logic [31:0] pd_word_r;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [31:0] rdata_r;
   logic [IRQ_W-1:0] irq_stat_nxt;
   logic [31:0] rdata_nxt;
   logic addr_phase;
   logic wr_now;
   logic msi_here;
   logic pd_here;
   logic pd_start;
   logic pd_start_wr;
   logic pd_refused;
   logic pd_busy;
   logic pd_done;
   logic [31:0] pd_rd_word;
   logic [31:0] msg_ctrl_word;
   logic [31:0] pd_ctrl_word;
   logic [31:0] vend_word;
   logic [31:0] msg_addr_word;
   logic pd_fill_r;
   logic wr_msg_ctrl;
   logic wr_msg_addr;
   logic wr_msg_uaddr;
   logic wr_msg_data;
   logic wr_pd_ctrl;
   logic wr_pd_word;
   logic wr_irq_stat;
   logic wr_irq_mask;
   logic rd_msg_ctrl;
   logic rd_msg_addr;
   logic rd_msg_uaddr;
   logic rd_msg_data;
   logic rd_pd_ctrl;
   logic rd_pd_word;
   logic rd_vend;
   logic rd_irq_stat;
   logic rd_irq_mask;

   // Register word hit for a given offset, used by both read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Port role caught after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         down_r <= 1'b0;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         down_r <= port_is_downstream;
         strap_done_r <= 1'b1;
      end
   end

   assign msi_here = down_r;
   assign pd_here = !down_r;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode, zero wait state slave
   assign addr_phase = hsel && hready && htrans[1];
   assign wr_now = wr_pend_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= haddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data-phase write strobes, absent groups never written
   assign wr_msg_ctrl = wr_now && msi_here && hit(wr_addr_r, OFF_MSG_CTRL);
   assign wr_msg_addr = wr_now && msi_here && hit(wr_addr_r, OFF_MSG_ADDR);
   assign wr_msg_uaddr = wr_now && msi_here && hit(wr_addr_r, OFF_MSG_UADDR);
   assign wr_msg_data = wr_now && msi_here && hit(wr_addr_r, OFF_MSG_DATA);
   assign wr_pd_ctrl = wr_now && pd_here && hit(wr_addr_r, OFF_PD_CTRL);
   assign wr_pd_word = wr_now && pd_here && hit(wr_addr_r, OFF_PD_WORD);
   assign wr_irq_stat = wr_now && hit(wr_addr_r, OFF_IRQ_STATUS);
   assign wr_irq_mask = wr_now && hit(wr_addr_r, OFF_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////
   // Message interrupt registers, downstream only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         msi_en_r <= 1'b0;
         mme_r <= RST_MME;
         msg_addr_r <= '0;
         msg_uaddr_r <= RST_WORD;
         msg_data_r <= 16'h0000;
      end else begin
         if (wr_msg_ctrl) begin
            msi_en_r <= hwdata[MSI_EN_BIT];
            mme_r <= hwdata[22:20];
         end
         if (wr_msg_addr) begin
            msg_addr_r <= hwdata[31:2];
         end
         if (wr_msg_uaddr) begin
            msg_uaddr_r <= hwdata;
         end
         if (wr_msg_data) begin
            msg_data_r <= hwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Product-data control and data, upstream only
   assign pd_start = wr_pd_ctrl && !pd_busy
      && (!hwdata[PD_OP_BIT] || hwdata[PD_WEN_BIT]);
   assign pd_start_wr = hwdata[PD_OP_BIT];
   assign pd_refused = wr_pd_ctrl && hwdata[PD_OP_BIT] && !hwdata[PD_WEN_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_addr_r <= '0;
         pd_wen_r <= 1'b0;
         pd_op_r <= 1'b0;
         pd_word_r <= RST_WORD;
         pd_fill_r <= 1'b0;
      end else begin
         if (wr_pd_ctrl && !pd_busy) begin
            pd_addr_r <= hwdata[PD_ADDR_LSB +: PD_ADDR_W];
            pd_wen_r <= hwdata[PD_WEN_BIT];
         end
         if (pd_start) begin
            pd_op_r <= pd_start_wr;
         end else if (pd_done) begin
            pd_op_r <= !pd_op_r;
         end
         pd_fill_r <= pd_done && !ee_write; // Engine word valid after done
         if (pd_fill_r) begin
            pd_word_r <= pd_rd_word;
         end else if (wr_pd_word && !pd_busy) begin
            pd_word_r <= hwdata;
         end
      end
   end

   pd_engine #(
      .AW(PD_ADDR_W)
   ) u_pd (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(pd_start),
      .start_write(pd_start_wr),
      .start_addr(hwdata[PD_ADDR_LSB +: PD_ADDR_W]),
      .start_wdata(pd_word_r),
      .busy(pd_busy),
      .done(pd_done),
      .rd_word(pd_rd_word),
      .ee_req(ee_req),
      .ee_write(ee_write),
      .ee_addr(ee_addr),
      .ee_wdata(ee_wdata),
      .ee_done(ee_done),
      .ee_rdata(ee_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Message sender
   msi_sender u_msi (
      .hclk(hclk),
      .hresetn(hresetn),
      .msi_en(msi_en_r && msi_here),
      .addr64(msg_ctrl_word[ADDR64_BIT]),
      .msg_addr(msg_addr_word),
      .msg_uaddr(msg_uaddr_r),
      .msg_data(msg_data_r),
      .irq_req(irq_req),
      .irq_level(irq_level),
      .msg_wr_valid(msg_wr_valid),
      .msg_wr_ready(msg_wr_ready),
      .msg_wr_addr(msg_wr_addr),
      .msg_wr_payload(msg_wr_payload),
      .intx_assert(intx_assert)
   );

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, set beats write-one-to-clear
   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (wr_irq_stat) begin
         irq_stat_nxt = irq_stat_nxt & ~hwdata[IRQ_W-1:0];
      end
      if (pd_done) begin
         irq_stat_nxt[IRQ_PD_DONE] = 1'b1;
      end
      if (pd_refused) begin
         irq_stat_nxt[IRQ_PD_REFUSED] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr_irq_mask) begin
            irq_mask_r <= hwdata[IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////
   // Read words
   assign msg_ctrl_word = {8'h00, 1'b1, mme_r, 3'b000, msi_en_r, NEXT_VEND, MSI_CAP_ID};
   assign msg_addr_word = {msg_addr_r, 2'b00};
   assign pd_ctrl_word = {pd_op_r, pd_wen_r, 6'h00, pd_addr_r, 2'b00, NEXT_VEND, PD_CAP_ID};
   assign vend_word = {VEND_LEN, NEXT_SSID, VEND_CAP_ID};

   // Read selects, absent groups read as zero
   assign rd_msg_ctrl = msi_here && hit(haddr, OFF_MSG_CTRL);
   assign rd_msg_addr = msi_here && hit(haddr, OFF_MSG_ADDR);
   assign rd_msg_uaddr = msi_here && hit(haddr, OFF_MSG_UADDR);
   assign rd_msg_data = msi_here && hit(haddr, OFF_MSG_DATA);
   assign rd_pd_ctrl = pd_here && hit(haddr, OFF_PD_CTRL);
   assign rd_pd_word = pd_here && hit(haddr, OFF_PD_WORD);
   assign rd_vend = hit(haddr, OFF_VEND_HDR);
   assign rd_irq_stat = hit(haddr, OFF_IRQ_STATUS);
   assign rd_irq_mask = hit(haddr, OFF_IRQ_MASK);

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (rd_msg_ctrl) begin
         rdata_nxt = msg_ctrl_word;
      end else if (rd_msg_addr) begin
         rdata_nxt = msg_addr_word;
      end else if (rd_msg_uaddr) begin
         rdata_nxt = msg_uaddr_r;
      end else if (rd_msg_data) begin
         rdata_nxt = {16'h0000, msg_data_r};
      end else if (rd_pd_ctrl) begin
         rdata_nxt = pd_ctrl_word;
      end else if (rd_pd_word) begin
         rdata_nxt = pd_word_r;
      end else if (rd_vend) begin
         rdata_nxt = vend_word;
      end else if (rd_irq_stat) begin
         rdata_nxt = {30'h0, irq_stat_r};
      end else if (rd_irq_mask) begin
         rdata_nxt = {30'h0, irq_mask_r};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= RST_WORD;
      end else if (addr_phase && !hwrite) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign hrdata = rdata_r;

endmodule // msi_vpd_capability_regs

//--- logic/cap_regs_pkg.sv
// Purpose: Shared constants for the capability register bank
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes: Offsets are byte addresses
package cap_regs_pkg;

   // Register offsets
   localparam logic [7:0] OFF_MSG_CTRL = 8'h4c;
   localparam logic [7:0] OFF_MSG_ADDR = 8'h50;
   localparam logic [7:0] OFF_MSG_UADDR = 8'h54;
   localparam logic [7:0] OFF_MSG_DATA = 8'h58;
   localparam logic [7:0] OFF_PD_CTRL = 8'h5c;
   localparam logic [7:0] OFF_PD_WORD = 8'h60;
   localparam logic [7:0] OFF_VEND_HDR = 8'h64;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h84;

   // Field positions
   localparam int MSI_EN_BIT = 16;
   localparam int ADDR64_BIT = 23;
   localparam int PD_WEN_BIT = 30;
   localparam int PD_OP_BIT = 31;
   localparam int PD_ADDR_LSB = 18;
   localparam int PD_ADDR_W = 6;

   // Fixed header values
   localparam logic [7:0] MSI_CAP_ID = 8'h05;
   localparam logic [7:0] PD_CAP_ID = 8'h03;
   localparam logic [7:0] VEND_CAP_ID = 8'h09;
   localparam logic [7:0] NEXT_VEND = 8'h64;
   localparam logic [7:0] NEXT_SSID = 8'hb0;
   localparam logic [15:0] VEND_LEN = 16'h0034;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_MME = 3'h0;

   // Interrupt status bits
   localparam int IRQ_PD_DONE = 0;
   localparam int IRQ_PD_REFUSED = 1;
   localparam int IRQ_W = 2;

   // Product-data engine states
   typedef enum logic [1:0] {
      PD_IDLE = 2'b00,
      PD_READ = 2'b01,
      PD_WRITE = 2'b10
   } pd_state_t;

endpackage

//--- logic/msi_sender.sv
// Purpose: Issues message-signalled interrupt writes or legacy level
// Assumes: Request is a pulse from same-clock logic
// Notes: Send request holds until the fabric accepts it
`timescale 1ns/1ps
module msi_sender
   import cap_regs_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Configuration
   input wire logic msi_en,
   input wire logic addr64,
   input wire logic [31:0] msg_addr,
   input wire logic [31:0] msg_uaddr,
   input wire logic [15:0] msg_data,
   // Service request in
   input wire logic irq_req,
   input wire logic irq_level,
   // Message write out
   output logic msg_wr_valid,
   input wire logic msg_wr_ready,
   output logic [63:0] msg_wr_addr,
   output logic [31:0] msg_wr_payload,
   // Legacy pin
   output logic intx_assert
);

   logic pend_r;
   logic [63:0] addr_r;
   logic [31:0] pay_r;
   logic [63:0] addr_nxt;

   // Aligned address, upper half only in 64-bit mode
   assign addr_nxt = {(addr64 ? msg_uaddr : 32'h0000_0000), msg_addr[31:2], 2'b00};

   ////////////////////////////////////////////////////////////////////////
   // Capture one request while messages are enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r <= 1'b0;
         addr_r <= 64'h0000_0000_0000_0000;
         pay_r <= RST_WORD;
      end else if (pend_r) begin
         if (msg_wr_ready) begin
            pend_r <= 1'b0;
         end
      end else if (irq_req && msi_en) begin
         pend_r <= 1'b1;
         addr_r <= addr_nxt;
         pay_r <= {16'h0000, msg_data};
      end
   end

   assign msg_wr_valid = pend_r;
   assign msg_wr_addr = addr_r;
   assign msg_wr_payload = pay_r;
   // Legacy signalling only while messages are off
   assign intx_assert = irq_level && !msi_en;

endmodule // msi_sender

//--- logic/pd_engine.sv
// Purpose: Sequences one product-data table access to the EEPROM port
// Assumes: EEPROM controller answers with a done pulse
// Notes: One access at a time; start ignored while busy
`timescale 1ns/1ps
module pd_engine
   import cap_regs_pkg::*;
#(
   parameter int AW = PD_ADDR_W
)(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Start from the register bank
   input wire logic start,
   input wire logic start_write,
   input wire logic [AW-1:0] start_addr,
   input wire logic [31:0] start_wdata,
   output logic busy,
   output logic done,
   output logic [31:0] rd_word,
   // EEPROM side
   output logic ee_req,
   output logic ee_write,
   output logic [AW-1:0] ee_addr,
   output logic [31:0] ee_wdata,
   input wire logic ee_done,
   input wire logic [31:0] ee_rdata
);

   pd_state_t state_r;
   logic [AW-1:0] addr_r;
   logic [31:0] wdata_r;
   logic [31:0] rd_r;

   ////////////////////////////////////////////////////////////////////////
   // Access state machine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= PD_IDLE;
         addr_r <= '0;
         wdata_r <= RST_WORD;
         rd_r <= RST_WORD;
      end else begin
         case (state_r)
            PD_IDLE: begin
               if (start) begin
                  state_r <= start_write ? PD_WRITE : PD_READ;
                  addr_r <= start_addr;
                  wdata_r <= start_wdata;
               end
            end
            PD_READ: begin
               if (ee_done) begin
                  state_r <= PD_IDLE;
                  rd_r <= ee_rdata;
               end
            end
            PD_WRITE: begin
               if (ee_done) begin
                  state_r <= PD_IDLE;
               end
            end
            default: state_r <= PD_IDLE;
         endcase
      end
   end

   assign busy = (state_r != PD_IDLE);
   assign done = busy && ee_done;
   assign rd_word = rd_r;
   assign ee_req = busy;
   assign ee_write = (state_r == PD_WRITE);
   assign ee_addr = addr_r;
   assign ee_wdata = wdata_r;

endmodule // pd_engine

//--- test/msi_vpd_capability_regs_checker.sv
// Purpose: Port-level checks of the capability register bank
// Assumes: Role strap changes only while reset is held
// Notes: Bound to the top module below
`timescale 1ns/1ps
module msi_vpd_capability_regs_checker
   import cap_regs_pkg::*;
(
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic port_is_downstream,
   // Message side
   input wire logic msg_wr_valid,
   input wire logic msg_wr_ready,
   input wire logic [63:0] msg_wr_addr,
   input wire logic [31:0] msg_wr_payload,
   input wire logic intx_assert,
   // EEPROM side
   input wire logic ee_req,
   input wire logic ee_write,
   input wire logic [5:0] ee_addr,
   input wire logic [31:0] ee_wdata,
   input wire logic ee_done
);
   logic ctl_dp_r;
   logic [31:0] wd_r;
   // Flags the data phase of a product-data control write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ctl_dp_r <= 1'b0;
      else ctl_dp_r <= hsel & hready & htrans[1] & hwrite & (haddr == OFF_PD_CTRL);
   end
   // Keeps the written word for the cycle after
   always_ff @(posedge hclk) begin
      wd_r <= hwdata;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_addr_align: assert property (msg_wr_valid |-> msg_wr_addr[1:0] == 2'b00)
      else $error("message address not aligned");
   a_msg_hold: assert property (msg_wr_valid && !msg_wr_ready |=> msg_wr_valid
      && $stable(msg_wr_addr) && $stable(msg_wr_payload))
      else $error("message write dropped or changed");
   a_payload_width: assert property (msg_wr_valid |-> msg_wr_payload[31:16] == 16'h0000)
      else $error("payload upper half not zero");
   a_msi_intx: assert property (msg_wr_valid |-> !intx_assert)
      else $error("legacy pin with message write");
   a_ee_hold: assert property (ee_req && !ee_done |=> ee_req && $stable(ee_addr)
      && $stable(ee_write) && $stable(ee_wdata))
      else $error("access dropped or changed early");
   a_ee_drop: assert property (ee_req && ee_done |=> !ee_req)
      else $error("access not ended after done");
   a_pd_start: assert property (ctl_dp_r && !ee_req && !port_is_downstream
      && (!hwdata[PD_OP_BIT] || hwdata[PD_WEN_BIT])
      |=> ee_req && ee_write == wd_r[PD_OP_BIT] && ee_addr == wd_r[23:18])
      else $error("access start wrong");
   a_wr_gate: assert property (ctl_dp_r && !ee_req && hwdata[PD_OP_BIT]
      && !hwdata[PD_WEN_BIT] |=> !ee_req)
      else $error("write without enable");
   a_pd_absent: assert property (ctl_dp_r && port_is_downstream && !ee_req |=> !ee_req)
      else $error("access on downstream port");
endmodule // msi_vpd_capability_regs_checker

bind msi_vpd_capability_regs msi_vpd_capability_regs_checker u_chk (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .port_is_downstream, .msg_wr_valid,
   .msg_wr_ready, .msg_wr_addr, .msg_wr_payload, .intx_assert, .ee_req, .ee_write,
   .ee_addr, .ee_wdata, .ee_done);

//--- test/eeprom_model.sv
// Purpose: Serial EEPROM table behind the access port
// Assumes: One access at a time, request held until done
// Notes: Latency set by the bench; read data toggles outside done
`timescale 1ns/1ps
module eeprom_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Access port
   input wire logic ee_req,
   input wire logic ee_write,
   input wire logic [5:0] ee_addr,
   input wire logic [31:0] ee_wdata,
   input wire logic [3:0] lat,
   output logic ee_done,
   output logic [31:0] ee_rdata
);
   logic [31:0] mem [64];
   logic [3:0] cnt;
   // Counts out the latency, then stores or fetches one word
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 4'h0;
         ee_done <= 1'b0;
         ee_rdata <= 32'h0000_0000;
      end else begin
         ee_done <= 1'b0;
         ee_rdata <= ~ee_rdata;
         if (ee_req && !ee_done && cnt == lat - 4'h1) begin
            ee_done <= 1'b1;
            cnt <= 4'h0;
            if (ee_write) mem[ee_addr] <= ee_wdata;
            else ee_rdata <= mem[ee_addr];
         end else if (ee_req && !ee_done) cnt <= cnt + 4'h1;
      end
   end
endmodule // eeprom_model

//--- test/msi_vpd_capability_regs_bench.sv
// Purpose: Self-checking bench of the capability register bank
// Assumes: Zero-wait slave, EEPROM model on the access port
// Notes: Upstream role first, then downstream after a second reset
`timescale 1ns/1ps
module msi_vpd_capability_regs_bench
   import cap_regs_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, port_is_downstream = 1'b0;
   logic irq_req = 1'b0, irq_level = 1'b0, msg_wr_ready = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, hresp, msg_wr_valid, intx_assert, ee_req, ee_write, ee_done, irq;
   logic [31:0] hrdata, msg_wr_payload, ee_wdata, ee_rdata, v, d, ad, ua, md;
   logic [63:0] msg_wr_addr;
   logic [5:0] ee_addr, a;
   logic [3:0] lat = 4'h4;
   int fail_count = 0, checks_done = 0;
   // Clock
   always #4 hclk = ~hclk;
   msi_vpd_capability_regs u_msi_vpd_capability_regs (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .port_is_downstream, .irq_req, .irq_level, .msg_wr_valid, .msg_wr_ready, .msg_wr_addr,
      .msg_wr_payload, .intx_assert, .ee_req, .ee_write, .ee_addr, .ee_wdata, .ee_done,
      .ee_rdata, .irq);
   eeprom_model u_eeprom_model (.hclk, .hresetn, .ee_req, .ee_write, .ee_addr, .ee_wdata,
      .lat, .ee_done, .ee_rdata);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] pd_ctl(input logic op, input logic wen, input logic [5:0] x);
      return {op, wen, 6'h00, x, 2'b00, NEXT_VEND, PD_CAP_ID};
   endfunction
   task automatic bus(input logic wr, input logic [7:0] ax, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= ax;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] ax, input logic [31:0] exp);
      bus(1'b0, ax, 32'h0000_0000);
      chk(v, exp);
   endtask
   task automatic pd_wait(input logic want);
      for (int n = 0; n < 40; n++) begin
         bus(1'b0, OFF_PD_CTRL, 32'h0000_0000);
         if (v[PD_OP_BIT] === want) break;
      end
   endtask
   task automatic settle();
      repeat (2) @(posedge hclk);
      @(negedge hclk);
   endtask
   task automatic go_reset(input logic down);
      hresetn <= 1'b0;
      port_is_downstream <= down;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end
   // Main sequence: upstream product data, interrupts, then downstream messages
   initial begin
      void'($urandom(32'h4fb0));
      go_reset(1'b0);
      rchk(OFF_VEND_HDR, {VEND_LEN, NEXT_SSID, VEND_CAP_ID});
      rchk(OFF_PD_CTRL, pd_ctl(1'b0, 1'b0, 6'h00));
      bus(1'b1, OFF_MSG_ADDR, 32'hffff_ffff);
      rchk(OFF_MSG_ADDR, 32'h0000_0000);
      rchk(8'h90, 32'h0000_0000);
      bus(1'b1, OFF_IRQ_MASK, 32'h0000_0003);
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 6'h3f : 6'($urandom);
         d = $urandom;
         lat <= 4'h4 + 4'($urandom % 4);
         bus(1'b1, OFF_PD_WORD, d);
         bus(1'b1, OFF_PD_CTRL, pd_ctl(1'b1, 1'b1, a));
         rchk(OFF_PD_CTRL, pd_ctl(1'b1, 1'b1, a));
         pd_wait(1'b0);
         chk(v, pd_ctl(1'b0, 1'b1, a));
         chk(u_eeprom_model.mem[a], d);
         bus(1'b1, OFF_PD_WORD, ~d);
         bus(1'b1, OFF_PD_CTRL, pd_ctl(1'b0, 1'b0, a));
         pd_wait(1'b1);
         chk(v, pd_ctl(1'b1, 1'b0, a));
         rchk(OFF_PD_WORD, d);
      end
      settle();
      chk({31'h0, irq}, 32'h0000_0001);
      chk({30'h0, hresp, hreadyout}, 32'h0000_0001);
      bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0003);
      bus(1'b1, OFF_PD_WORD, ~d);
      bus(1'b1, OFF_PD_CTRL, pd_ctl(1'b1, 1'b0, a));
      settle();
      chk(u_eeprom_model.mem[a], d);
      rchk(OFF_IRQ_STATUS, 32'h0000_0002);
      bus(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
      settle();
      chk({31'h0, irq}, 32'h0000_0000);
      bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0002);
      rchk(OFF_IRQ_STATUS, 32'h0000_0000);
      go_reset(1'b1);
      rchk(OFF_MSG_CTRL, {8'h00, 1'b1, 7'h00, NEXT_VEND, MSI_CAP_ID});
      bus(1'b1, OFF_PD_WORD, 32'hffff_ffff);
      bus(1'b1, OFF_PD_CTRL, pd_ctl(1'b0, 1'b0, 6'h01));
      rchk(OFF_PD_WORD, 32'h0000_0000);
      rchk(OFF_PD_CTRL, 32'h0000_0000);
      ad = $urandom | 32'h0000_0003;
      ua = $urandom;
      md = $urandom;
      irq_level <= 1'b1;
      bus(1'b1, OFF_MSG_ADDR, ad);
      bus(1'b1, OFF_MSG_UADDR, ua);
      bus(1'b1, OFF_MSG_DATA, md);
      rchk(OFF_MSG_ADDR, {ad[31:2], 2'b00});
      rchk(OFF_MSG_DATA, {16'h0000, md[15:0]});
      settle();
      chk({31'h0, intx_assert}, 32'h0000_0001);
      bus(1'b1, OFF_MSG_CTRL, 32'h0051_0000);
      rchk(OFF_MSG_CTRL, {8'h00, 1'b1, 3'h5, 3'h0, 1'b1, NEXT_VEND, MSI_CAP_ID});
      settle();
      chk({31'h0, intx_assert}, 32'h0000_0000);
      @(posedge hclk);
      irq_req <= 1'b1;
      @(posedge hclk);
      irq_req <= 1'b0;
      for (int n = 0; n < 20; n++) begin
         @(negedge hclk);
         if (msg_wr_valid === 1'b1) break;
      end
      repeat (3) @(negedge hclk);
      chk({31'h0, msg_wr_valid}, 32'h0000_0001);
      chk(msg_wr_addr[63:32], ua);
      chk(msg_wr_addr[31:0], {ad[31:2], 2'b00});
      chk(msg_wr_payload, {16'h0000, md[15:0]});
      @(posedge hclk);
      msg_wr_ready <= 1'b1;
      @(posedge hclk);
      msg_wr_ready <= 1'b0;
      @(negedge hclk);
      chk({31'h0, msg_wr_valid}, 32'h0000_0000);
      end_of_test();
   end
endmodule // msi_vpd_capability_regs_bench
